/* core/dos_filter.sv */
// Purpose: Denial-of-service header filter with AHB-Lite control registers.
// Assumes: The parser presents one header summary per frame on hclk.
// Notes:   Mirroring sits downstream and ignores drop_forward.
//
// Summary of operation
// - Flag any IP frame whose destination address equals its source.
// - Flag TCP with equal ports in unfragmented or first-fragment frames.
// - Flag UDP with equal ports in unfragmented or first-fragment frames.
// - Flag TCP with zero sequence and no flag bits set.
// - Flag TCP with zero sequence and FIN, URG, PSH all set.
// - Flag TCP SYN without ACK from a source port below 1024.
// - Flag TCP header shorter than the programmed minimum.
// - Flag TCP fragments whose fragment offset is exactly one.
// - Flag ICMPv4 or ICMPv6 carried in fragmented datagrams, separately.
// - Flag unfragmented ICMPv4 echo longer than maximum plus IPv4 header.
// - Flag unfragmented ICMPv6 echo whose payload exceeds the maximum.
// - Minimum TCP header size programmable 0 to 255, resets to 20.
// - Maximum ICMPv4 size programmable up to 9.6 KB, resets to 512.
// - Each attack type has its own drop control, all clear after reset.
// - One global control allows address learning on flagged frames.
// - Dropped frames leave normal forwarding; mirror copies still go out.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "dos_filter_regs.svh"

module dos_filter #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         ce,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic [31:0]                       hrdata,
  output logic                              hresp,
  input  wire logic                         hdr_valid,
  input  wire logic                         is_ipv4,
  input  wire logic                         is_ipv6,
  input  wire logic [127:0]                 ip_src,
  input  wire logic [127:0]                 ip_dst,
  input  wire logic                         more_frag,
  input  wire logic [12:0]                  frag_offset,
  input  wire logic                         is_tcp,
  input  wire logic                         is_udp,
  input  wire logic                         is_icmp4,
  input  wire logic                         is_icmp6,
  input  wire logic [7:0]                   icmp_type,
  input  wire logic [15:0]                  src_port,
  input  wire logic [15:0]                  dst_port,
  input  wire logic [31:0]                  tcp_seq,
  input  wire logic [5:0]                   tcp_flags,
  input  wire logic [7:0]                   tcp_hdr_bytes,
  input  wire logic [15:0]                  ip4_total_len,
  input  wire logic [5:0]                   ip4_hdr_bytes,
  input  wire logic [15:0]                  ip6_payload_len,
  output logic                              flags_valid,
  output logic [`NUM_ATTACKS-1:0]           attack_flags,
  output logic                              drop_forward,
  output logic                              learn_allow,
  output logic                              irq
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
    $error("dos_filter: ADDR_W must lie between 5 and 32.");
  end

  dos_filter_pkg::top_state_t st;
  dos_filter_pkg::top_state_t next_st;

  hdr_if hif ();

  logic       addr_take;
  logic       in_window;
  logic [7:0] word_addr;
  logic       rd_status;

  // Writes beyond the documented ceiling saturate rather than wrap, so a
  // careless value never turns into a tiny limit.
  function automatic dos_filter_pkg::thresh_t clamp_size(
    input logic [31:0] word
  );
    if (word > {18'h00000, `ICMP_MAX_LIMIT}) begin
      clamp_size = `ICMP_MAX_LIMIT;
    end else begin
      clamp_size = word[`THRESH_W-1:0];
    end
  endfunction

  function automatic logic [31:0] read_word(
    input dos_filter_pkg::top_state_t s,
    input logic [7:0]                 a
  );
    read_word = 32'h0000_0000;
    unique case (a)
      `OFS_DROP_CTRL: begin
        read_word[`NUM_ATTACKS-1:0] = s.drop_ctrl;
        read_word[`LEARN_BIT]       = s.learn_on_attack;
      end
      `OFS_TCP_MIN:    read_word[7:0]             = s.tcp_header_min_bytes;
      `OFS_ICMP4_MAX:  read_word[`THRESH_W-1:0]   = s.icmp4_max_bytes;
      `OFS_ICMP6_MAX:  read_word[`THRESH_W-1:0]   = s.icmp6_max_bytes;
      `OFS_IRQ_STATUS: read_word[`NUM_ATTACKS-1:0] = s.status;
      `OFS_IRQ_MASK:   read_word[`NUM_ATTACKS-1:0] = s.mask;
      `OFS_LAST_FLAGS: read_word[`NUM_ATTACKS-1:0] = s.last_flags;
      default:         read_word = 32'h0000_0000;
    endcase
  endfunction

  assign hif.is_ipv4         = is_ipv4;
  assign hif.is_ipv6         = is_ipv6;
  assign hif.ip_src          = ip_src;
  assign hif.ip_dst          = ip_dst;
  assign hif.more_frag       = more_frag;
  assign hif.frag_offset     = frag_offset;
  assign hif.is_tcp          = is_tcp;
  assign hif.is_udp          = is_udp;
  assign hif.is_icmp4        = is_icmp4;
  assign hif.is_icmp6        = is_icmp6;
  assign hif.icmp_type       = icmp_type;
  assign hif.src_port        = src_port;
  assign hif.dst_port        = dst_port;
  assign hif.tcp_seq         = tcp_seq;
  assign hif.tcp_flags       = tcp_flags;
  assign hif.tcp_hdr_bytes   = tcp_hdr_bytes;
  assign hif.ip4_total_len   = ip4_total_len;
  assign hif.ip4_hdr_bytes   = ip4_hdr_bytes;
  assign hif.ip6_payload_len = ip6_payload_len;
  assign hif.tcp_min         = st.tcp_header_min_bytes;
  assign hif.icmp4_max       = st.icmp4_max_bytes;
  assign hif.icmp6_max       = st.icmp6_max_bytes;

  dos_checker u_checker (
    .h (hif.chk)
  );

  always_comb begin
    in_window = 1'b1;
    if (ADDR_W < 32) begin
      in_window = ((haddr >> ADDR_W) == 32'h0000_0000);
    end
    word_addr = {haddr[7:2], 2'b00};
    addr_take = ce & hsel & htrans[1] & hready;
    rd_status = addr_take & ~hwrite & in_window
                & (word_addr == `OFS_IRQ_STATUS);
  end

  always_comb begin
    next_st = st;

    // Address phase: capture the transfer and prepare read data at once,
    // so the slave answers with no wait state.
    if (ce & hready) begin
      next_st.ph_valid = addr_take & in_window;
      next_st.ph_write = hwrite;
      next_st.ph_addr  = word_addr;
    end
    if (addr_take & ~hwrite) begin
      next_st.rdata = in_window ? read_word(st, word_addr) : 32'h0000_0000;
    end

    // Data phase write.
    if (ce & st.ph_valid & st.ph_write) begin
      unique case (st.ph_addr)
        `OFS_DROP_CTRL: begin
          next_st.drop_ctrl       = hwdata[`NUM_ATTACKS-1:0];
          next_st.learn_on_attack = hwdata[`LEARN_BIT];
        end
        `OFS_TCP_MIN:   next_st.tcp_header_min_bytes = hwdata[7:0];
        `OFS_ICMP4_MAX: next_st.icmp4_max_bytes = clamp_size(hwdata);
        `OFS_ICMP6_MAX: next_st.icmp6_max_bytes = clamp_size(hwdata);
        `OFS_IRQ_MASK:  next_st.mask = hwdata[`NUM_ATTACKS-1:0];
        default: ;
      endcase
    end

    // Reading the status clears it; an attack in the same cycle still sets.
    if (rd_status) begin
      next_st.status = '0;
    end

    next_st.res_valid = 1'b0;
    if (ce & hdr_valid) begin
      next_st.res_valid  = 1'b1;
      next_st.last_flags = hif.flags;
      next_st.res_drop   = |(hif.flags & st.drop_ctrl);
      next_st.res_learn  = ~(|hif.flags) | st.learn_on_attack;
      next_st.status     = next_st.status | hif.flags;
    end

    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st                      <= '0;
      st.drop_ctrl            <= `RST_DROP_CTRL;
      st.learn_on_attack      <= `RST_LEARN;
      st.tcp_header_min_bytes <= `RST_TCP_MIN;
      st.icmp4_max_bytes      <= `RST_ICMP_MAX;
      st.icmp6_max_bytes      <= `RST_ICMP_MAX;
      st.res_learn            <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // The slave never stretches a transfer except while the block is frozen.
  assign hreadyout    = ce;
  assign hresp        = 1'b0;
  assign hrdata       = st.rdata;
  assign flags_valid  = st.res_valid;
  assign attack_flags = st.last_flags;
  assign drop_forward = st.res_drop;
  assign learn_allow  = st.res_learn;
  assign irq          = st.irq;

endmodule

/* core/dos_filter_regs.svh */
// Purpose: Register map, field positions, reset values and limits.
// Assumes: Word-aligned 32-bit registers on AHB-Lite.
// Notes:   Included by bare name; definitions only.
`ifndef DOS_FILTER_REGS_SVH
`define DOS_FILTER_REGS_SVH

`define OFS_DROP_CTRL        8'h00
`define OFS_TCP_MIN          8'h04
`define OFS_ICMP4_MAX        8'h08
`define OFS_ICMP6_MAX        8'h0C
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h14
`define OFS_LAST_FLAGS       8'h18

`define NUM_ATTACKS          13
`define THRESH_W             14
`define LEARN_BIT            16

`define RST_DROP_CTRL        13'h0000
`define RST_LEARN            1'b0
`define RST_TCP_MIN          8'h14
`define RST_ICMP_MAX         14'h0200
`define ICMP_MAX_LIMIT       14'h2666

`define LOW_PORT_LIMIT       16'h0400
`define ICMP4_ECHO_REQ       8'h08
`define ICMP6_ECHO_REQ       8'h80

`define TCP_FIN              0
`define TCP_SYN              1
`define TCP_RST              2
`define TCP_PSH              3
`define TCP_ACK              4
`define TCP_URG              5

`endif

/* core/dos_filter_pkg.sv */
// Purpose: Types shared by the attack filter modules.
// Assumes: Widths follow dos_filter_regs.svh.
// Notes:   Nothing here is imported; users write dos_filter_pkg::name.
`include "dos_filter_regs.svh"

package dos_filter_pkg;

  typedef enum logic [3:0] {
    same_ip_address_attack     = 4'h0,
    tcp_same_port_attack       = 4'h1,
    udp_same_port_attack       = 4'h2,
    tcp_no_flags_scan          = 4'h3,
    tcp_fin_urg_psh_scan       = 4'h4,
    syn_fin_scan_a             = 4'h5,
    tcp_low_port_syn_error     = 4'h6,
    tcp_short_header           = 4'h7,
    tcp_fragment_offset_error  = 4'h8,
    icmp4_fragmented           = 4'h9,
    icmp6_fragmented           = 4'hA,
    icmp4_oversize_echo        = 4'hB,
    icmp6_oversize_echo        = 4'hC
  } attack_idx_t;

  typedef logic [`NUM_ATTACKS-1:0] attack_vec_t;
  typedef logic [`THRESH_W-1:0]    thresh_t;

  typedef struct packed {
    attack_vec_t  drop_ctrl;
    logic         learn_on_attack;
    logic [7:0]   tcp_header_min_bytes;
    thresh_t      icmp4_max_bytes;
    thresh_t      icmp6_max_bytes;
    attack_vec_t  status;
    attack_vec_t  mask;
    attack_vec_t  last_flags;
    logic         res_valid;
    logic         res_drop;
    logic         res_learn;
    logic         irq;
    logic         ph_valid;
    logic         ph_write;
    logic [7:0]   ph_addr;
    logic [31:0]  rdata;
  } top_state_t;

endpackage

/* core/hdr_if.sv */
// Purpose: Carries one frame's header summary and thresholds to the checker.
// Assumes: All signals are on the switch core clock.
// Notes:   The checker is purely combinational; the top registers its answer.
`timescale 1ns/100ps

interface hdr_if;
  logic                          is_ipv4;
  logic                          is_ipv6;
  logic [127:0]                  ip_src;
  logic [127:0]                  ip_dst;
  logic                          more_frag;
  logic [12:0]                   frag_offset;
  logic                          is_tcp;
  logic                          is_udp;
  logic                          is_icmp4;
  logic                          is_icmp6;
  logic [7:0]                    icmp_type;
  logic [15:0]                   src_port;
  logic [15:0]                   dst_port;
  logic [31:0]                   tcp_seq;
  logic [5:0]                    tcp_flags;
  logic [7:0]                    tcp_hdr_bytes;
  logic [15:0]                   ip4_total_len;
  logic [5:0]                    ip4_hdr_bytes;
  logic [15:0]                   ip6_payload_len;
  logic [7:0]                    tcp_min;
  dos_filter_pkg::thresh_t       icmp4_max;
  dos_filter_pkg::thresh_t       icmp6_max;
  dos_filter_pkg::attack_vec_t   flags;

  modport src (
    output is_ipv4, is_ipv6, ip_src, ip_dst, more_frag, frag_offset,
    output is_tcp, is_udp, is_icmp4, is_icmp6, icmp_type,
    output src_port, dst_port, tcp_seq, tcp_flags, tcp_hdr_bytes,
    output ip4_total_len, ip4_hdr_bytes, ip6_payload_len,
    output tcp_min, icmp4_max, icmp6_max,
    input  flags
  );

  modport chk (
    input  is_ipv4, is_ipv6, ip_src, ip_dst, more_frag, frag_offset,
    input  is_tcp, is_udp, is_icmp4, is_icmp6, icmp_type,
    input  src_port, dst_port, tcp_seq, tcp_flags, tcp_hdr_bytes,
    input  ip4_total_len, ip4_hdr_bytes, ip6_payload_len,
    input  tcp_min, icmp4_max, icmp6_max,
    output flags
  );
endinterface

/* core/dos_checker.sv */
// Purpose: Evaluates every attack pattern on one header summary.
// Assumes: IPv4 addresses sit in the low 32 bits, upper bits zero.
// Notes:   Combinational; the top samples flags on the frame strobe.
`timescale 1ns/100ps
`include "dos_filter_regs.svh"

module dos_checker (
  hdr_if.chk h
);

  logic        fragmented;
  logic        head_piece;
  logic        any_ip;
  logic [16:0] v4_limit;

  always_comb begin
    fragmented = h.more_frag | (h.frag_offset != 13'h0000);
    head_piece = (h.frag_offset == 13'h0000);
    any_ip     = h.is_ipv4 | h.is_ipv6;
    v4_limit   = {3'b000, h.icmp4_max} + {11'h000, h.ip4_hdr_bytes};
    h.flags    = '0;
    h.flags[dos_filter_pkg::same_ip_address_attack] =
      any_ip & (h.ip_dst == h.ip_src);
    h.flags[dos_filter_pkg::tcp_same_port_attack] =
      any_ip & h.is_tcp & head_piece & (h.dst_port == h.src_port);
    h.flags[dos_filter_pkg::udp_same_port_attack] =
      any_ip & h.is_udp & head_piece & (h.dst_port == h.src_port);
    h.flags[dos_filter_pkg::tcp_no_flags_scan] =
      any_ip & h.is_tcp & head_piece & (h.tcp_seq == 32'h0000_0000)
      & (h.tcp_flags == 6'h00);
    h.flags[dos_filter_pkg::tcp_fin_urg_psh_scan] =
      any_ip & h.is_tcp & head_piece & (h.tcp_seq == 32'h0000_0000)
      & h.tcp_flags[`TCP_FIN] & h.tcp_flags[`TCP_URG]
      & h.tcp_flags[`TCP_PSH];
    h.flags[dos_filter_pkg::syn_fin_scan_a] =
      any_ip & h.is_tcp & head_piece
      & h.tcp_flags[`TCP_SYN] & h.tcp_flags[`TCP_FIN];
    h.flags[dos_filter_pkg::tcp_low_port_syn_error] =
      any_ip & h.is_tcp & head_piece & h.tcp_flags[`TCP_SYN]
      & ~h.tcp_flags[`TCP_ACK] & (h.src_port < `LOW_PORT_LIMIT);
    h.flags[dos_filter_pkg::tcp_short_header] =
      any_ip & h.is_tcp & head_piece
      & (h.tcp_hdr_bytes < h.tcp_min);
    h.flags[dos_filter_pkg::tcp_fragment_offset_error] =
      any_ip & h.is_tcp & fragmented
      & (h.frag_offset == 13'h0001);
    h.flags[dos_filter_pkg::icmp4_fragmented] =
      h.is_ipv4 & h.is_icmp4 & fragmented;
    h.flags[dos_filter_pkg::icmp6_fragmented] =
      h.is_ipv6 & h.is_icmp6 & fragmented;
    h.flags[dos_filter_pkg::icmp4_oversize_echo] =
      h.is_ipv4 & h.is_icmp4 & ~fragmented
      & (h.icmp_type == `ICMP4_ECHO_REQ)
      & ({1'b0, h.ip4_total_len} > v4_limit);
    h.flags[dos_filter_pkg::icmp6_oversize_echo] =
      h.is_ipv6 & h.is_icmp6 & ~fragmented
      & (h.icmp_type == `ICMP6_ECHO_REQ)
      & (h.ip6_payload_len > {2'b00, h.icmp6_max});
  end

endmodule

/* verif/dos_filter_monitor.sv */
// Purpose: Concurrent checks on the filter verdict ports.
// Assumes: One clock domain; hresetn is active low.
// Notes:   Bound to the filter after the module.
`timescale 1ns/100ps

module dos_filter_monitor (
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         ce,
  input wire logic         hdr_valid,
  input wire logic         is_ipv4,
  input wire logic         is_ipv6,
  input wire logic [127:0] ip_src,
  input wire logic [127:0] ip_dst,
  input wire logic         more_frag,
  input wire logic [12:0]  frag_offset,
  input wire logic         is_tcp,
  input wire logic         is_icmp4,
  input wire logic [15:0]  src_port,
  input wire logic [5:0]   tcp_flags,
  input wire logic         flags_valid,
  input wire logic [12:0]  attack_flags,
  input wire logic         drop_forward,
  input wire logic         learn_allow
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A header counts only while the clock enable runs.
  wire take = hdr_valid && ce;
  wire tcp1 = take && is_tcp && frag_offset == 13'h0000;
  wire none = attack_flags == 13'h0000;

  // A frozen cycle keeps the old verdict, so only running edges are checked.
  property p_strobe; ce |=> flags_valid == $past(hdr_valid); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe late");
  property p_hold; !take |=> $stable(attack_flags); endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
  property p_land;
    take && (is_ipv4 || is_ipv6) && ip_src == ip_dst |=> attack_flags[0];
  endproperty
  a_land: assert property (p_land) else $error("same ip missed");
  property p_synfin; tcp1 && tcp_flags[1] && tcp_flags[0] |=> attack_flags[5];
  endproperty
  a_synfin: assert property (p_synfin) else $error("syn fin missed");
  property p_lowsyn;
    tcp1 && tcp_flags[1] && !tcp_flags[4] && src_port < 16'h0400
      |=> attack_flags[6];
  endproperty
  a_lowsyn: assert property (p_lowsyn) else $error("syn low missed");
  property p_frag;
    take && is_tcp && frag_offset == 13'h0001 |=> attack_flags[8];
  endproperty
  a_frag: assert property (p_frag) else $error("offset one missed");
  property p_icmp;
    take && is_icmp4 && (more_frag || frag_offset != 13'h0000)
      |=> attack_flags[9];
  endproperty
  a_icmp: assert property (p_icmp) else $error("icmp frag missed");
  property p_nodrop; flags_valid && none |-> !drop_forward; endproperty
  a_nodrop: assert property (p_nodrop) else $error("clean drop");
  property p_learn; flags_valid && none |-> learn_allow; endproperty
  a_learn: assert property (p_learn) else $error("clean no learn");
endmodule

bind dos_filter dos_filter_monitor mon_u (
  .hclk, .hresetn, .ce, .hdr_valid, .is_ipv4, .is_ipv6, .ip_src, .ip_dst,
  .more_frag, .frag_offset, .is_tcp, .is_icmp4, .src_port, .tcp_flags,
  .flags_valid, .attack_flags, .drop_forward, .learn_allow);

/* verif/fwd_model.sv */
// Purpose: Forwarding stage acting on each frame verdict.
// Assumes: The verdict is read in the flags_valid cycle only.
// Notes:   Mirror copies ignore the drop verdict.
`timescale 1ns/100ps

module fwd_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic flags_valid,
  input  wire logic drop_forward,
  output int        fwd_cnt,
  output int        mir_cnt
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_cnt <= 0;
      mir_cnt <= 0;
    end else if (flags_valid) begin
      mir_cnt <= mir_cnt + 1;
      if (!drop_forward) begin
        fwd_cnt <= fwd_cnt + 1;
      end
    end
  end
endmodule

/* verif/dos_filter_tb.sv */
// Purpose: Self-checking bench for the attack filter.
// Assumes: 100 MHz clock; ce high except in one freeze test, word hsize.
// Notes:   A fixed seed keeps every random frame repeatable.
`timescale 1ns/100ps
`include "dos_filter_regs.svh"

module dos_filter_tb;
  typedef struct packed {
    logic         v4, v6, mf, tcp, udp, i4, i6;
    logic [12:0]  off;
    logic [127:0] sa, da;
    logic [7:0]   ty, hb;
    logic [15:0]  sp, dp, tl, pl;
    logic [31:0]  seq;
    logic [5:0]   fl, h4;
  } hdr_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hdr_valid = 1'b0, learn_en = 1'b0, ce = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0]  tmin = 8'h14;
  logic [13:0] max4 = 14'h0200, max6 = 14'h0200;
  logic [12:0] drops = 13'h0000, exp, attack_flags;
  logic        hreadyout, hresp, flags_valid, drop_forward, learn_allow, irq;
  hdr_t        h = '0, lf;
  int          num_errors = 0, cmp_count = 0, fwd_exp = 0, mir_exp = 0;
  int          fwd_cnt, mir_cnt;

  dos_filter dut_u (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .hdr_valid, .is_ipv4(h.v4), .is_ipv6(h.v6), .ip_src(h.sa),
    .ip_dst(h.da), .more_frag(h.mf), .frag_offset(h.off), .is_tcp(h.tcp),
    .is_udp(h.udp), .is_icmp4(h.i4), .is_icmp6(h.i6), .icmp_type(h.ty),
    .src_port(h.sp), .dst_port(h.dp), .tcp_seq(h.seq), .tcp_flags(h.fl),
    .tcp_hdr_bytes(h.hb), .ip4_total_len(h.tl), .ip4_hdr_bytes(h.h4),
    .ip6_payload_len(h.pl), .flags_valid, .attack_flags, .drop_forward,
    .learn_allow, .irq);
  fwd_model part_u (.hclk, .hresetn, .flags_valid, .drop_forward,
                    .fwd_cnt, .mir_cnt);

  always #5 hclk = ~hclk;

  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
    chk("hresp", hresp, 32'h0);
  endtask

  function automatic logic [12:0] expect_flags(input hdr_t r);
    logic fr, f0;
    logic [12:0] e;
    fr = r.mf || r.off != 0;
    f0 = r.tcp && r.off == 0;
    e[0] = (r.v4 || r.v6) && r.sa == r.da;
    e[1] = f0 && r.sp == r.dp;
    e[2] = r.udp && r.off == 0 && r.sp == r.dp;
    e[3] = f0 && r.seq == 0 && r.fl == 0;
    e[4] = f0 && r.seq == 0 && r.fl[0] && r.fl[5] && r.fl[3];
    e[5] = f0 && r.fl[1] && r.fl[0];
    e[6] = f0 && r.fl[1] && !r.fl[4] && r.sp < 1024;
    e[7] = f0 && r.hb < tmin;
    e[8] = r.tcp && r.off == 1;
    e[9] = r.i4 && fr;
    e[10] = r.i6 && fr;
    e[11] = r.i4 && !fr && r.ty == 8 && r.tl > max4 + r.h4;
    e[12] = r.i6 && !fr && r.ty == 128 && r.pl > max6;
    return e;
  endfunction

  function automatic hdr_t rnd();
    logic [31:0] b;
    b = $urandom;
    return '{v4: b[0], v6: !b[0], tcp: !b[2], udp: b[2] & !b[1],
      i4: b[2] & b[1] & b[0], i6: b[2] & b[1] & !b[0], mf: b[4] & b[3],
      off: b[6:5] % 3, sa: b[8:7], da: b[10:9], ty: b[11] ? 8'h08 : 8'h80,
      sp: b[31:21], dp: b[12] ? b[31:21] : $urandom, h4: 6'h14,
      seq: b[13] ? 32'h0 : $urandom, fl: $urandom, hb: $urandom,
      tl: $urandom % 1100, pl: $urandom % 1100};
  endfunction

  task automatic frame(input hdr_t r);
    @(posedge hclk);
    h <= r;
    hdr_valid <= 1'b1;
    exp = expect_flags(r);
    @(posedge hclk);
    hdr_valid <= 1'b0;
    @(negedge hclk);
    chk("flags_valid", flags_valid, 1);
    chk("flags", attack_flags, exp);
    chk("drop", drop_forward, |(exp & drops));
    chk("learn", learn_allow, exp == 0 || learn_en);
    mir_exp++;
    fwd_exp += !(|(exp & drops));
  endtask

  task automatic cfg(input logic [12:0] d, input logic l);
    drops = d;
    learn_en = l;
    bus(1'b1, `OFS_DROP_CTRL, {15'h0, l, 3'h0, d});
  endtask

  initial begin
    void'($urandom(32'hF106));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("tcp_min", `OFS_TCP_MIN, 32'h14);
    rdchk("icmp4_max", `OFS_ICMP4_MAX, 32'h200);
    rdchk("icmp6_max", `OFS_ICMP6_MAX, 32'h200);
    rdchk("drop_ctrl", `OFS_DROP_CTRL, 32'h0);
    rdchk("unmapped", 8'h1C, 32'h0);
    repeat (150) frame(rnd());
    // Port and length boundaries sit on either side of the limit.
    for (int i = 0; i < 2; i++) begin
      frame('{v4: 1, tcp: 1, fl: 6'h02, sp: 16'h03FF + i, default: 0});
      frame('{v4: 1, i4: 1, ty: 8'h08, h4: 6'h14, tl: 16'h0214 + i,
              default: 0});
    end
    $display("test defaults done");
    tmin = 8'hFF;
    max4 = 14'h0;
    max6 = `ICMP_MAX_LIMIT;
    bus(1'b1, `OFS_TCP_MIN, 32'hFF);
    bus(1'b1, `OFS_ICMP4_MAX, 32'h0);
    bus(1'b1, `OFS_ICMP6_MAX, 32'hFFFF);
    rdchk("tcp_min", `OFS_TCP_MIN, 32'hFF);
    rdchk("icmp4_max", `OFS_ICMP4_MAX, 32'h0);
    rdchk("icmp6_max", `OFS_ICMP6_MAX, {18'h0, `ICMP_MAX_LIMIT});
    cfg(13'h1FFF, 1'b0);
    repeat (80) frame(rnd());
    cfg(13'h0555, 1'b1);
    repeat (80) frame(rnd());
    rdchk("drop_ctrl", `OFS_DROP_CTRL, 32'h10555);
    $display("test drop and learn done");
    lf = '{v4: 1, sa: 128'h5, da: 128'h5, default: 0};
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    frame(lf);
    @(negedge hclk);
    chk("irq masked", irq, 1'b0);
    rdchk("last_flags", `OFS_LAST_FLAGS, 32'h1);
    rdchk("status", `OFS_IRQ_STATUS, 32'h1);
    rdchk("status clear", `OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    frame(lf);
    @(negedge hclk);
    chk("irq", irq, 1'b1);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    repeat (2) @(negedge hclk);
    chk("irq clear", irq, 1'b0);
    // A header offered while frozen must leave no trace once running again.
    @(posedge hclk);
    ce <= 1'b0;
    h <= lf;
    hdr_valid <= 1'b1;
    @(negedge hclk);
    chk("hreadyout frozen", hreadyout, 1'b0);
    @(posedge hclk);
    ce <= 1'b1;
    hdr_valid <= 1'b0;
    repeat (2) @(negedge hclk);
    chk("frozen valid", flags_valid, 1'b0);
    chk("frozen irq", irq, 1'b0);
    chk("forwarded", fwd_cnt, fwd_exp);
    chk("mirrored", mir_cnt, mir_exp);
    $display("test interrupt done");
    summarize();
  end

  // Roughly ten times the cycles the tests need; a hang ends here.
  initial begin
    #(70_000);
    num_errors++;
    summarize();
  end
endmodule
